// >>> tx_backplane_if.sv
/*
  Transmit backplane interface: AHB-Lite control register, pin sampling on a
  link clock, frame alignment and byte (de)multiplexing to four channels.
  Assumes the link clock oversamples every backplane clock at least 2x and
  that configuration changes only while the backplane is quiet.
*/
// The AHB-Lite register port is this design's own decision.
// What this block does
// R1: Clock-edge invert 0: data changes on rising edge; 1: on falling edge.
// R2: Edge invert honoured only at base rate; ignored in high-speed or muxed modes.
// R3: Mux enable 1 accepts four channels on one stream; 0 turns mux off.
// R4: Muxed mode runs backplane at 16.384MHz; partner supplies data at that rate.
// R5: Speed select field decoded differently for mux enable set or clear.
// R6: No mux, 00: 2.048Mbit/s base rate, serial clock input or output.
// R7: Base rate: superframe sync marks 2ms, frame sync marks each 125us frame.
// R8: No mux, 01: superframe pin becomes 2.048MHz high-speed sampling clock.
// R9: No mux, 10: 4.096Mbit/s, superframe pin is 4.096MHz data clock.
// R10: No mux, 11: 8.192Mbit/s, superframe pin is 8.192MHz data clock.
// R11: Non-base modes: serial clock pin is 2.048MHz input, data pin high-speed.
// R12: High-speed non-muxed: partner drives frame sync at each frame boundary.
// R13: Mux 00/01 reserved; 10 demuxes bytes to channels 0-3, sync spans 4 bits.
// R14: Mux 11: frame sync high only last bit of previous, first of current.
`timescale 1ns/1ps
module tx_backplane_if
  import tx_backplane_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tx_link_clk_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Backplane pins
  input wire logic tx_serial_clock_pin_i,
  output logic tx_serial_clock_pin_o,
  output logic tx_serial_clock_pin_oe_o,
  input wire logic tx_superframe_sync_pin_i,
  input wire logic tx_frame_sync_pin_i,
  input wire logic tx_serial_data_pin_i,
  // Received bytes toward the framers
  output logic byte_valid_o,
  output byte_s byte_o
);
  // ==========================================================================
  // System domain: bus slave and registers
  cfg_s cfg, next_cfg;
  logic drive, next_drive;
  logic flen_err, next_flen_err;
  logic sf_err, next_sf_err;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic rsv_sys;
  logic addr_phase;
  logic flen_ev, sf_ev, byte_ev;
  logic [31:0] wdat;

  // Reserved mux codes only exist with the multiplexer on
  assign rsv_sys = cfg.mux & ~cfg.mode[1]; // R13
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign wdat = hwdata_i;

  // Next register values; hardware error set wins over a write-one clear
  always_comb begin
    next_cfg = cfg;
    next_drive = drive;
    next_flen_err = flen_err;
    next_sf_err = sf_err;
    next_wr_pend = addr_phase & hwrite_i;
    next_wr_addr = addr_phase ? haddr_i[11:0] : wr_addr;
    if (wr_pend) begin
      unique case (wr_addr)
        CTRL_ADDR: begin
          next_cfg.invert = wdat[INV_BIT]; // R1
          next_cfg.mux = wdat[MUX_BIT]; // R3
          next_cfg.mode = wdat[MODE_LSB+:2]; // R5
        end
        AUX_ADDR: next_drive = wdat[AUX_DRIVE_BIT];
        STAT_ADDR: begin
          if (wdat[STAT_FLEN_BIT]) next_flen_err = 1'b0;
          if (wdat[STAT_SF_BIT]) next_sf_err = 1'b0;
        end
        default: ;
      endcase
    end
    if (flen_ev) next_flen_err = 1'b1; // R7
    if (sf_ev) next_sf_err = 1'b1; // R7
    // Read data prepared in the address phase so the data phase has no wait
    next_hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite_i) begin
      unique case (haddr_i[11:0])
        CTRL_ADDR: next_hrdata[7:0] = {4'h0, cfg.invert, cfg.mux, cfg.mode};
        AUX_ADDR: next_hrdata[AUX_DRIVE_BIT] = drive;
        STAT_ADDR: begin
          next_hrdata[7:0] = byte_o.data;
          next_hrdata[STAT_CHAN_LSB+:2] = byte_o.chan;
          next_hrdata[STAT_FLEN_BIT] = flen_err;
          next_hrdata[STAT_SF_BIT] = sf_err;
          next_hrdata[STAT_RSV_BIT] = rsv_sys;
        end
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Register stage of the bus slave; every transfer is zero-wait OKAY
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= cfg_s'(CTRL_RESET[3:0]);
      drive <= 1'b0;
      flen_err <= 1'b0;
      sf_err <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      drive <= next_drive;
      flen_err <= next_flen_err;
      sf_err <= next_sf_err;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ==========================================================================
  // System domain: serial clock output at base rate
  logic [4:0] div_cnt, next_div_cnt;
  logic next_sclk, next_sclk_oe;

  // Only base rate may drive the pin; 50 MHz gives about 2.08 MHz, not exact
  always_comb begin
    next_sclk_oe = drive & ~cfg.mux & (cfg.mode == MODE_BASE); // R6 R11
    next_div_cnt = div_cnt + 5'h01;
    next_sclk = tx_serial_clock_pin_o;
    if (div_cnt == SERCLK_HALF_DIV - 5'h01) begin
      next_div_cnt = 5'h00;
      next_sclk = ~tx_serial_clock_pin_o;
    end
    if (!next_sclk_oe) next_sclk = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 5'h00;
      tx_serial_clock_pin_o <= 1'b0;
      tx_serial_clock_pin_oe_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tx_serial_clock_pin_o <= next_sclk;
      tx_serial_clock_pin_oe_o <= next_sclk_oe;
    end
  end

  // ==========================================================================
  // Link domain: reset release, config and pin synchronisers
  logic [1:0] lrst_q;
  logic lrst_n;
  cfg_s cfg_m, cfg_l;
  logic [3:0] pin_m, pin_s;
  logic [1:0] clk_d;
  // Pin order: serial clock, superframe sync, frame sync, data
  always_ff @(posedge tx_link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  // Config is quasi-static, so a per-bit two-flop sync is enough
  always_ff @(posedge tx_link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_m <= cfg_s'(CTRL_RESET[3:0]);
      cfg_l <= cfg_s'(CTRL_RESET[3:0]);
      pin_m <= 4'h0;
      pin_s <= 4'h0;
      clk_d <= 2'b00;
    end else begin
      cfg_m <= cfg;
      cfg_l <= cfg_m;
      pin_m <= {tx_serial_clock_pin_i, tx_superframe_sync_pin_i,
                tx_frame_sync_pin_i, tx_serial_data_pin_i};
      pin_s <= pin_m;
      clk_d <= pin_s[3:2];
    end
  end

  // ==========================================================================
  // Link domain: edge choice, alignment and byte assembly
  logic hs, rsv, clk_now, clk_prev, sample;
  logic [2:0] need_run, run, next_run;
  logic [10:0] exp_len, bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [1:0] bidx, next_bidx;
  logic [3:0] fnum, next_fnum;
  logic framed, next_framed, start, push;
  byte_s hold, next_hold;
  logic btgl, next_btgl, ftgl, next_ftgl, stgl, next_stgl;

  // Any high-speed or muxed mode clocks data on the superframe pin
  assign hs = cfg_l.mux | (cfg_l.mode != MODE_BASE); // R5 R8 R9 R10
  assign rsv = cfg_l.mux & ~cfg_l.mode[1]; // R13
  assign clk_now = hs ? pin_s[2] : pin_s[3]; // R11
  assign clk_prev = hs ? clk_d[0] : clk_d[1];
  // Sample on the edge opposite the data transition; high-speed always rising
  assign sample = hs ? (clk_now & ~clk_prev) : // R2
    (cfg_l.invert ? (clk_now & ~clk_prev) : (~clk_now & clk_prev)); // R1
  // Count of sync-high bits, ending on the first bit of a frame, that marks a frame start
  assign need_run = !cfg_l.mux ? SYNC_RUN_SINGLE : // R12
    (cfg_l.mode == MODE_H100 ? SYNC_RUN_H100 : SYNC_RUN_HMVIP); // R13 R14
  // Frame length in bits follows the line rate of each non-muxed mode; muxed expects 2047
  assign exp_len = cfg_l.mux ? MUX_FRAME_BITS : // R4
    (cfg_l.mode == MODE_8M ? BASE_FRAME_BITS << 2 : // R10
    (cfg_l.mode == MODE_4M ? BASE_FRAME_BITS << 1 : BASE_FRAME_BITS)); // R6 R9
  assign start = sample & ~rsv & pin_s[1] & (run + 3'h1 == need_run);
  // Byte done on the eighth bit after a start; taken from the registered count
  // so the next-state process never reads a value derived from its own output
  assign push = sample & ~rsv & framed & ~start & (bit_cnt[2:0] == 3'h7);

  always_comb begin
    next_run = run;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_bidx = bidx;
    next_fnum = fnum;
    next_framed = framed;
    next_hold = hold;
    next_btgl = btgl;
    next_ftgl = ftgl;
    next_stgl = stgl;
    if (sample && !rsv) begin
      next_run = pin_s[1] ? ((run == 3'h7) ? run : run + 3'h1) : 3'h0;
      next_shreg = {shreg[6:0], pin_s[0]};
      next_bit_cnt = start ? 11'h001 : bit_cnt + 11'h001;
      if (start) begin
        // A frame that ends early or late is flagged to software
        if (framed && bit_cnt != exp_len) next_ftgl = ~ftgl; // R7
        next_framed = 1'b1;
        next_bidx = 2'h0;
        if (!hs) begin
          next_fnum = pin_s[2] ? 4'h0 : fnum + 4'h1; // R7
          if (framed && pin_s[2] && fnum != LAST_FRAME) next_stgl = ~stgl; // R7
        end
      end
    end
    if (push) begin
      next_hold.data = {shreg[6:0], pin_s[0]};
      next_hold.chan = cfg_l.mux ? bidx : 2'h0; // R3 R13
      next_bidx = bidx + 2'h1;
      next_btgl = ~btgl;
    end
  end

  always_ff @(posedge tx_link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      run <= 3'h0;
      bit_cnt <= 11'h000;
      shreg <= 8'h00;
      bidx <= 2'h0;
      fnum <= 4'h0;
      framed <= 1'b0;
      hold <= '0;
      btgl <= 1'b0;
      ftgl <= 1'b0;
      stgl <= 1'b0;
    end else begin
      run <= next_run;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      bidx <= next_bidx;
      fnum <= next_fnum;
      framed <= next_framed;
      hold <= next_hold;
      btgl <= next_btgl;
      ftgl <= next_ftgl;
      stgl <= next_stgl;
    end
  end

  // ==========================================================================
  // Toggle crossings back to the system domain
  logic [2:0] tg_m, tg_s, tg_d;
  byte_s next_byte;
  // Order: byte, frame length error, superframe error
  assign byte_ev = tg_s[0] ^ tg_d[0];
  assign flen_ev = tg_s[1] ^ tg_d[1];
  assign sf_ev = tg_s[2] ^ tg_d[2];
  // Hold register is stable for many link cycles after each toggle
  assign next_byte = byte_ev ? hold : byte_o;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tg_m <= 3'h0;
      tg_s <= 3'h0;
      tg_d <= 3'h0;
      byte_o <= '0;
      byte_valid_o <= 1'b0;
    end else begin
      tg_m <= {stgl, ftgl, btgl};
      tg_s <= tg_m;
      tg_d <= tg_s;
      byte_o <= next_byte;
      byte_valid_o <= byte_ev;
    end
  end

  // ==========================================================================
  // Assertions
  ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_pend && wr_addr == CTRL_ADDR |=> cfg.mux == $past(hwdata_i[MUX_BIT])) // R3
    else $error("control write not stored");
  sclk_base_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_serial_clock_pin_oe_o |-> $past(!cfg.mux && cfg.mode == MODE_BASE)) // R6
    else $error("serial clock driven outside base rate");
  sclk_input_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg.mux || cfg.mode != MODE_BASE) |-> ##1 !tx_serial_clock_pin_oe_o) // R11
    else $error("serial clock not an input in high-speed mode");
  base_edge_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    sample && !hs && !cfg_l.invert |-> !pin_s[3] && clk_d[1]) // R1
    else $error("base rate sampled on wrong edge");
  hs_edge_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    sample && hs |-> pin_s[2] && !clk_d[0]) // R2
    else $error("high-speed sampling not on rising edge");
  chan_zero_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    push && !cfg_l.mux |=> hold.chan == 2'h0) // R3
    else $error("channel set without multiplexing");
  rsv_quiet_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    cfg_l.mux && !cfg_l.mode[1] |-> !push && !start) // R13
    else $error("data taken in reserved mode");
  h100_start_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    start && cfg_l.mux && cfg_l.mode == MODE_H100 |-> run == 3'h1) // R14
    else $error("H.100 frame start after wrong sync length");
  len_8m_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    !cfg_l.mux && cfg_l.mode == MODE_8M |-> exp_len == 11'h400) // R10
    else $error("8.192 frame length wrong");
  mux_len_a: assert property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    cfg_l.mux |-> exp_len == 11'h7FF) // R4
    else $error("muxed frame length wrong");
  valid_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    byte_valid_o |=> !byte_valid_o) // R3
    else $error("byte valid held two cycles");
  flen_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flen_ev |=> flen_err) // R7
    else $error("frame length error lost");
  mux_byte_c: cover property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    push && cfg_l.mux && bidx == 2'h3);
  frame_start_c: cover property (@(posedge tx_link_clk_i) disable iff (!lrst_n)
    start && framed);
  flen_err_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) flen_ev);
  sclk_drive_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_serial_clock_pin_oe_o);
endmodule

// >>> tx_backplane_interface_mode_bench.sv
/*
  Self-checking bench: AHB-Lite register tasks plus partner frames.
  Assumes zero-wait slave and bytes out within a few system cycles.
*/
`timescale 1ns/1ps
module tx_backplane_interface_mode_bench;
  import tx_backplane_pkg::*;
  // ==========================================================================
  // Signals
  logic sys_clk_i, rst_n_i, tx_link_clk_i, hsel_i, hwrite_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_s, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  wire logic hready_i;
  wire logic sclk_pin;
  logic hreadyout_o, hresp_o, sclk_o, sclk_oe, byte_valid_o, rdy_s, last_sclk;
  byte_s byte_o;
  logic p_sclk, p_msync, p_fsync, p_data;
  logic [9:0] rx_q[$];
  int n_errors, tests_run, n_tog;
  // Single slave; shared pin resolved from the device enable
  assign hready_i = hreadyout_o;
  assign sclk_pin = sclk_oe ? sclk_o : p_sclk;
  tx_backplane_if tx_backplane_if_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tx_link_clk_i(tx_link_clk_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .tx_serial_clock_pin_i(sclk_pin), .tx_serial_clock_pin_o(sclk_o),
    .tx_serial_clock_pin_oe_o(sclk_oe), .tx_superframe_sync_pin_i(p_msync),
    .tx_frame_sync_pin_i(p_fsync), .tx_serial_data_pin_i(p_data),
    .byte_valid_o(byte_valid_o), .byte_o(byte_o)
  );
  tx_backplane_partner tx_backplane_partner_inst (
    .ser_clk_o(p_sclk), .msync_o(p_msync), .fsync_o(p_fsync), .data_o(p_data)
  );
  // ==========================================================================
  // Clocks: link clock unrelated in phase
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    tx_link_clk_i = 1'b0;
    #3;
    forever #16 tx_link_clk_i = ~tx_link_clk_i;
  end
  // Mid-cycle sampling avoids racing the design's own edge updates
  always @(negedge sys_clk_i) begin
    rdy_s <= hreadyout_o;
    rd_s <= hrdata_o;
    if (byte_valid_o === 1'b1) rx_q.push_back(byte_o);
  end
  // ==========================================================================
  // Tasks
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [9:0] exp);
    logic [9:0] got;
    got = (rx_q.size() > 0) ? rx_q.pop_front() : {10{1'bx}};
    check_reg({22'h0, got}, {22'h0, exp});
  endtask
  // One single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {20'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge sys_clk_i); while (rdy_s !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge sys_clk_i); while (rdy_s !== 1'b1);
    rd = rd_s;
    check_reg({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check_reg(rd & m, e);
  endtask
  task automatic frame(input logic [31:0] d, input int n, input int k, input logic hs,
                       input logic inv);
    tx_backplane_partner_inst.send_frame(d, n, k, hs, inv);
    repeat (20) @(posedge sys_clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge sys_clk_i);
    repeat (3) @(posedge tx_link_clk_i);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(CTRL_ADDR, 32'hFF, {24'h0, CTRL_RESET});
    rd_chk(AUX_ADDR, 32'h1, 32'h0);
    wr(12'h130, 32'hFF);
    rd_chk(12'h130, 32'hFFFFFFFF, 32'h0);
    wr(CTRL_ADDR, 32'h0F);
    rd_chk(CTRL_ADDR, 32'hFF, 32'h0F);
    $display("test registers done");
    // Device-driven serial clock: exact toggle count over a fixed window
    wr(CTRL_ADDR, 32'h00);
    wr(AUX_ADDR, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    n_tog = 0;
    last_sclk = sclk_o;
    repeat (48) begin
      @(negedge sys_clk_i);
      n_tog += int'(sclk_o !== last_sclk);
      last_sclk = sclk_o;
    end
    check_reg(32'(n_tog), 32'(48 / SERCLK_HALF_DIV));
    check_reg({31'h0, sclk_oe}, 32'h1);
    wr(AUX_ADDR, 32'h0);
    frame(32'hA53C0000, 16, 1, 1'b0, 1'b0);
    check_byte({8'hA5, 2'h0});
    check_byte({8'h3C, 2'h0});
    rd_chk(STAT_ADDR, 32'h3FF, 32'h03C);
    wr(CTRL_ADDR, 32'h08);
    frame(32'h96000000, 8, 1, 1'b0, 1'b1);
    check_byte({8'h96, 2'h0});
    // Second frame started far short of a full frame: sticky error, then W1C
    rd_chk(STAT_ADDR, 32'h1 << STAT_FLEN_BIT, 32'h1 << STAT_FLEN_BIT);
    wr(STAT_ADDR, 32'h1 << STAT_FLEN_BIT);
    rd_chk(STAT_ADDR, 32'h1 << STAT_FLEN_BIT, 32'h0);
    $display("test base rate done");
    // High-speed codes with invert set and clock drive requested
    wr(AUX_ADDR, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(CTRL_ADDR, 32'h08 | 32'(m));
      repeat (3) @(posedge sys_clk_i);
      check_reg({31'h0, sclk_oe}, 32'h0);
      frame({8'hC0 | 8'(m), 24'h0}, 8, 1, 1'b1, 1'b1);
      check_byte({8'hC0 | 8'(m), 2'h0});
    end
    $display("test high speed done");
    // Multiplexed: HMVIP with sync over four bits, H.100 over two
    for (int k = 2; k < 4; k++) begin
      wr(CTRL_ADDR, (k == 3) ? 32'h06 : 32'h0F);
      frame(32'h11223344 + 32'(k), 32, k, 1'b1, 1'b1);
      for (int c = 0; c < 4; c++) begin
        check_byte({8'((32'h11223344 + 32'(k)) >> (24 - 8 * c)), 2'(c)});
      end
    end
    $display("test multiplexed done");
    // Reserved multiplexed codes take nothing and flag it
    for (int m = 0; m < 2; m++) begin
      wr(CTRL_ADDR, 32'h04 | 32'(m));
      frame(32'hFF000000, 8, 1, 1'b1, 1'b0);
      check_reg(32'(rx_q.size()), 32'h0);
      rd_chk(STAT_ADDR, 32'h1 << STAT_RSV_BIT, 32'h1 << STAT_RSV_BIT);
    end
    $display("test reserved done");
    close_out;
  end
  // Run needs about 35 us; a hang is cut well beyond that
  initial begin
    #1_000_000;
    n_errors++;
    close_out;
  end
endmodule

// >>> tx_backplane_partner.sv
/*
  Backplane partner model: sends one frame per call on the
  sampling clock, frame sync and serial data pins.
  Assumes the bench sets the device mode before each frame.
*/
`timescale 1ns/1ps
module tx_backplane_partner (
  // Pins toward the device
  output logic ser_clk_o,
  output logic msync_o,
  output logic fsync_o,
  output logic data_o
);
  // Data lags the change edge, so a wrong sampling edge sees the old bit
  localparam time HALF = 96;
  localparam time SKEW = 40;
  // ==========================================================================
  // Idle pins
  initial begin
    ser_clk_o = 1'b0;
    msync_o = 1'b0;
    fsync_o = 1'b0;
    data_o = 1'b0;
  end
  // Two lead bits, then nbits of d MSB first; the clock stands still after
  task automatic send_frame(input logic [31:0] d, input int nbits, input int k,
                            input logic hs, input logic inv);
    logic lvl;
    lvl = hs | inv;
    if (hs) msync_o = lvl; else ser_clk_o = lvl;
    #HALF;
    for (int i = -2; i < nbits; i++) begin
      if (hs) msync_o = ~lvl; else ser_clk_o = ~lvl;
      #SKEW;
      data_o = (i < 0) ? ~data_o : d[31 - i];
      fsync_o = (i >= 1 - k) && (i <= k / 3);
      #(HALF - SKEW);
      if (hs) msync_o = lvl; else ser_clk_o = lvl;
      #HALF;
    end
    data_o = ~data_o; // Released line shows no stale bit
    fsync_o = 1'b0;
  endtask
endmodule

// >>> tx_backplane_pkg.sv
/*
  Constants, register map and carrier types for the transmit backplane
  interface block. Assumes a 50 MHz system clock and a register layout
  placed in the low 19 bits of 32-bit AHB-Lite words.
*/
package tx_backplane_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] CTRL_ADDR = 12'h120;
  localparam logic [11:0] AUX_ADDR = 12'h124;
  localparam logic [11:0] STAT_ADDR = 12'h128;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int INV_BIT = 3;
  localparam int MUX_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int AUX_DRIVE_BIT = 0;
  localparam int STAT_CHAN_LSB = 8;
  localparam int STAT_FLEN_BIT = 16;
  localparam int STAT_SF_BIT = 17;
  localparam int STAT_RSV_BIT = 18;
  // ==========================================================================
  // Speed select codes
  localparam logic [1:0] MODE_BASE = 2'b00;
  localparam logic [1:0] MODE_MVIP = 2'b01;
  localparam logic [1:0] MODE_4M = 2'b10;
  localparam logic [1:0] MODE_8M = 2'b11;
  localparam logic [1:0] MODE_HMVIP = 2'b10;
  localparam logic [1:0] MODE_H100 = 2'b11;
  // ==========================================================================
  // Framing and timing
  localparam logic [10:0] BASE_FRAME_BITS = 11'h100;
  localparam logic [10:0] MUX_FRAME_BITS = 11'h7FF;
  localparam int FRAME_US = 125;
  localparam int SUPERFRAME_US = 2000;
  localparam logic [3:0] LAST_FRAME = 4'(SUPERFRAME_US / FRAME_US - 1);
  localparam logic [2:0] SYNC_RUN_SINGLE = 3'h1;
  localparam logic [2:0] SYNC_RUN_H100 = 3'h2;
  localparam logic [2:0] SYNC_RUN_HMVIP = 3'h3;
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int SERCLK_HZ = 2_048_000;
  localparam logic [4:0] SERCLK_HALF_DIV = 5'(SYS_CLK_HZ / (2 * SERCLK_HZ));
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic invert;
    logic mux;
    logic [1:0] mode;
  } cfg_s;
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] chan;
  } byte_s;
endpackage
